// ==== sxc_regs.vh ====
// constants for the spindle external command logic
`ifndef SXC_REGS_VH
`define SXC_REGS_VH
`define SXC_SRC_ANALOG 2'h0
`define SXC_SRC_PULSE 2'h1
`define SXC_SRC_POINT 2'h2
`define SXC_SPD_W 16
`define SXC_SPD_MIN 16'h03e8
`define SXC_SPD_MAX 16'hc350
`define SXC_SPD_STEP 16'h03e8
`define SXC_SPD_AIRCAP 16'h7530
`define SXC_SPD_RST 16'h2710
`define SXC_CLK_MHZ 250
`define SXC_DEB_US 1000
`define SXC_HOLD_MS 3000
`define SXC_BEEP_MS 100
`define SXC_DEB_CYC 18'h3d090
`define SXC_HOLD_CYC 32'h2cb41780
`define SXC_BEEP_CYC 32'h017d7840
`define SXC_ERR_DEPTH 5
`define SXC_VIEW_PARAM 2'h1
`define SXC_VIEW_VERSION 2'h2
`define SXC_VIEW_ERRHIST 2'h3
`endif

// ==== sxc_debounce.v ====
// synchroniser and debounce filter for one contact input
`timescale 1ns/10ps
module sxc_debounce #(
  parameter CNT_W = 18,
  parameter [17:0] STABLE = 18'h3d090
) (
  input wire mclk,
  input wire rstn,
  input wire raw,
  output reg clean_r
);
  reg s1_r;
  reg s2_r;
  reg [CNT_W-1:0] cnt_r;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      cnt_r <= {CNT_W{1'b0}};
      clean_r <= 1'b0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      if (s2_r == clean_r) begin
        cnt_r <= {CNT_W{1'b0}};
      end else if (cnt_r == STABLE[CNT_W-1:0]) begin
        cnt_r <= {CNT_W{1'b0}};
        clean_r <= s2_r;
      end else begin
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // sxc_debounce

// ==== sxc_err_hist.v ====
// five-deep error code history, newest first
`timescale 1ns/10ps
`include "sxc_regs.vh"
module sxc_err_hist #(
  parameter CODE_W = 8,
  parameter DEPTH = `SXC_ERR_DEPTH
) (
  input wire mclk,
  input wire rstn,
  input wire err_valid,
  input wire [CODE_W-1:0] err_code,
  input wire clear,
  input wire [2:0] rd_slot,
  output reg [CODE_W-1:0] rd_code_r,
  output reg [2:0] count_r
);
  reg [CODE_W-1:0] mem_r [0:DEPTH-1];
  integer i;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_r[i] <= {CODE_W{1'b0}};
      end
      count_r <= 3'h0;
      rd_code_r <= {CODE_W{1'b0}};
    end else begin
      // a new error wins over clear
      if (err_valid) begin
        mem_r[0] <= err_code;
        for (i = 1; i < DEPTH; i = i + 1) begin
          mem_r[i] <= mem_r[i-1];
        end
        if (clear) begin
          count_r <= 3'h1;
        end else if (count_r != DEPTH[2:0]) begin
          count_r <= count_r + 3'h1;
        end
      end else if (clear) begin
        for (i = 0; i < DEPTH; i = i + 1) begin
          mem_r[i] <= {CODE_W{1'b0}};
        end
        count_r <= 3'h0;
      end
      if (rd_slot != 3'h0 && rd_slot <= DEPTH[2:0] && rd_slot <= count_r) begin
        rd_code_r <= mem_r[rd_slot - 3'h1];
      end else begin
        rd_code_r <= {CODE_W{1'b0}};
      end
    end
  end
endmodule // sxc_err_hist

// ==== sxc_top.v ====
// spindle external command logic: speed source, start, e-stop, lights, history
// Behaviour
// - auto mode speed source chosen by parameter: analog, pulse or speed point.
// - pulse mode uses select low as up/down and select high as count.
// - each count pulse moves active motor set speed by 1000 rpm.
// - up/down open lowers speed, closed raises speed.
// - pulse-set speeds of both motors kept in nonvolatile storage.
// - four speed points per motor; motor choice open is motor one.
// - select high is upper bit, closed is one; 00 to 11 picks points 1-4.
// - each speed point holds any speed from 1000 to 50000 rpm.
// - analog mode: motor one from first input, motor two from second.
// - signal start uses rotate command with direction sampled together.
// - direction open means forward, closed means reverse.
// - signal start disabled ignores direction and rotate command inputs.
// - air override allows start without air but caps speed at 30000.
// - characteristic parameter picks native 50000 curve or legacy curve.
// - estop enabled and both estop inputs open trips relay, cuts power.
// - estop parameter off means estop inputs are ignored.
// - four brightness levels each for front and bottom lights.
// - last five error codes kept, newest slot one, oldest dropped.
// - start/stop held three seconds in history view clears it and beeps.
// - read-only parameter view and program version view on indicator.
// - fixed and maximum speeds clamped to 1000 to 50000; any value, not rounded to 1000 steps.
`timescale 1ns/10ps
`include "sxc_regs.vh"
module sxc_top #(
  parameter SPD_W = `SXC_SPD_W,
  parameter CODE_W = 8,
  parameter [15:0] VERSION = 16'h0100,
  parameter [17:0] DEB_CYC = `SXC_DEB_CYC,
  parameter [31:0] HOLD_CYC = `SXC_HOLD_CYC,
  parameter [31:0] BEEP_CYC = `SXC_BEEP_CYC
) (
  input wire mclk,
  input wire rstn,
  input wire [1:0] speed_source_param,
  input wire legacy_curve_param,
  input wire signal_start_param,
  input wire air_override_param,
  input wire estop_enable_param,
  input wire max1_en_param,
  input wire [SPD_W-1:0] max1_speed_param,
  input wire max2_en_param,
  input wire [SPD_W-1:0] max2_speed_param,
  input wire fixed1_en_param,
  input wire [SPD_W-1:0] fixed1_speed_param,
  input wire fixed2_en_param,
  input wire [SPD_W-1:0] fixed2_speed_param,
  input wire [1:0] front_light_param,
  input wire [1:0] bottom_light_param,
  input wire [SPD_W-1:0] analog_speed_in_first,
  input wire [SPD_W-1:0] analog_speed_in_second,
  input wire [SPD_W-1:0] analog_legacy_first,
  input wire [SPD_W-1:0] analog_legacy_second,
  input wire speed_select_low,
  input wire speed_select_high,
  input wire motor_choice_in,
  input wire dir_in,
  input wire rotate_cmd_in,
  input wire estop_in_first,
  input wire estop_in_second,
  input wire air_ok_in,
  input wire point_wr,
  input wire point_wr_motor,
  input wire [1:0] point_wr_idx,
  input wire [SPD_W-1:0] point_wr_speed,
  input wire nv_load,
  input wire [SPD_W-1:0] nv_speed1,
  input wire [SPD_W-1:0] nv_speed2,
  input wire err_valid,
  input wire [CODE_W-1:0] err_code,
  input wire [1:0] view_sel,
  input wire [2:0] hist_slot,
  input wire start_stop_btn,
  output reg [SPD_W-1:0] speed_cmd_r,
  output reg run_r,
  output reg forward_rotation_r,
  output reg reverse_rotation_r,
  output reg estop_trip_r,
  output reg motor_power_en_r,
  output reg nv_write_r,
  output reg [SPD_W-1:0] nv_wr_speed1_r,
  output reg [SPD_W-1:0] nv_wr_speed2_r,
  output reg [1:0] front_light_r,
  output reg [1:0] bottom_light_r,
  output reg [15:0] indicator_r,
  output reg beep_r
);
  ////////////////////////////////////////////////////////////////////
  // input conditioning
  wire sel_lo_c;
  wire sel_hi_c;
  wire mot_c;
  wire dir_c;
  wire rot_c;
  wire es1_c;
  wire es2_c;
  wire btn_c;
  wire [7:0] raw_w;
  wire [7:0] clean_w;
  assign raw_w = {start_stop_btn, estop_in_second, estop_in_first, rotate_cmd_in,
                  dir_in, motor_choice_in, speed_select_high, speed_select_low};
  assign {btn_c, es2_c, es1_c, rot_c, dir_c, mot_c, sel_hi_c, sel_lo_c} = clean_w;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : deb
      sxc_debounce #(.CNT_W(18), .STABLE(DEB_CYC)) u_deb (
        .mclk(mclk),
        .rstn(rstn),
        .raw(raw_w[g]),
        .clean_r(clean_w[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // helpers
  function [15:0] clamp_spd;
    input [15:0] v;
    input [15:0] lim;
    reg [15:0] t;
    begin
      t = v;
      if (t < `SXC_SPD_MIN) t = `SXC_SPD_MIN;
      if (t > `SXC_SPD_MAX) t = `SXC_SPD_MAX;
      if (t > lim) t = lim;
      clamp_spd = t;
    end
  endfunction

  function [15:0] lim_of;
    input en;
    input [15:0] m;
    begin
      lim_of = en ? clamp_spd(m, `SXC_SPD_MAX) : `SXC_SPD_MAX;
    end
  endfunction

  wire [15:0] lim1_w;
  wire [15:0] lim2_w;
  assign lim1_w = lim_of(max1_en_param, max1_speed_param);
  assign lim2_w = lim_of(max2_en_param, max2_speed_param);

  ////////////////////////////////////////////////////////////////////
  // pulse mode counting
  reg cnt_d_r;
  reg [SPD_W-1:0] pset1_r;
  reg [SPD_W-1:0] pset2_r;
  wire pulse_mode;
  wire cnt_rise;
  reg [SPD_W-1:0] cur_p;
  reg [SPD_W-1:0] nxt_p;
  reg [16:0] sum_p;
  assign pulse_mode = (speed_source_param == `SXC_SRC_PULSE);
  assign cnt_rise = pulse_mode & sel_hi_c & ~cnt_d_r;

  always @* begin
    cur_p = mot_c ? pset2_r : pset1_r;
    sum_p = 17'h0;
    if (sel_lo_c) begin
      sum_p = {1'b0, cur_p} + {1'b0, `SXC_SPD_STEP};
    end else if (cur_p > `SXC_SPD_STEP) begin
      sum_p = {1'b0, cur_p} - {1'b0, `SXC_SPD_STEP};
    end
    nxt_p = clamp_spd(sum_p[16] ? `SXC_SPD_MAX : sum_p[15:0], mot_c ? lim2_w : lim1_w);
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_d_r <= 1'b0;
      pset1_r <= `SXC_SPD_RST;
      pset2_r <= `SXC_SPD_RST;
      nv_write_r <= 1'b0;
      nv_wr_speed1_r <= `SXC_SPD_RST;
      nv_wr_speed2_r <= `SXC_SPD_RST;
    end else begin
      cnt_d_r <= sel_hi_c;
      nv_write_r <= 1'b0;
      if (nv_load) begin
        pset1_r <= clamp_spd(nv_speed1, `SXC_SPD_MAX);
        pset2_r <= clamp_spd(nv_speed2, `SXC_SPD_MAX);
      end else if (cnt_rise) begin
        if (mot_c) pset2_r <= nxt_p;
        else pset1_r <= nxt_p;
        nv_write_r <= 1'b1;
        nv_wr_speed1_r <= mot_c ? pset1_r : nxt_p;
        nv_wr_speed2_r <= mot_c ? nxt_p : pset2_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // speed points
  reg [SPD_W-1:0] point_r [0:7];
  integer k;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (k = 0; k < 8; k = k + 1) begin
        point_r[k] <= `SXC_SPD_RST;
      end
    end else if (point_wr) begin
      point_r[{point_wr_motor, point_wr_idx}] <= clamp_spd(point_wr_speed, `SXC_SPD_MAX);
    end
  end
  wire [2:0] pt_idx;
  assign pt_idx = {mot_c, sel_hi_c, sel_lo_c};

  ////////////////////////////////////////////////////////////////////
  // speed command
  reg [SPD_W-1:0] raw_spd;
  reg [SPD_W-1:0] lim_spd;
  always @* begin
    lim_spd = mot_c ? lim2_w : lim1_w;
    if (air_override_param && !air_ok_in && lim_spd > `SXC_SPD_AIRCAP) begin
      lim_spd = `SXC_SPD_AIRCAP;
    end
    case (speed_source_param)
      `SXC_SRC_PULSE: raw_spd = mot_c ? pset2_r : pset1_r;
      `SXC_SRC_POINT: raw_spd = point_r[pt_idx];
      default: raw_spd = mot_c ? (legacy_curve_param ? analog_legacy_second
                                                     : analog_speed_in_second)
                               : (legacy_curve_param ? analog_legacy_first
                                                     : analog_speed_in_first);
    endcase
    if (!mot_c && fixed1_en_param) raw_spd = fixed1_speed_param;
    if (mot_c && fixed2_en_param) raw_spd = fixed2_speed_param;
  end

  ////////////////////////////////////////////////////////////////////
  // start, direction, emergency stop
  reg trip_nxt;
  always @* begin
    trip_nxt = estop_enable_param & ~es1_c & ~es2_c;
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      speed_cmd_r <= `SXC_SPD_MIN;
      run_r <= 1'b0;
      forward_rotation_r <= 1'b0;
      reverse_rotation_r <= 1'b0;
      estop_trip_r <= 1'b0;
      motor_power_en_r <= 1'b0;
      front_light_r <= 2'h0;
      bottom_light_r <= 2'h0;
    end else begin
      speed_cmd_r <= clamp_spd(raw_spd, lim_spd);
      estop_trip_r <= trip_nxt;
      motor_power_en_r <= ~trip_nxt & (air_ok_in | air_override_param);
      if (signal_start_param && !trip_nxt && (air_ok_in || air_override_param)) begin
        run_r <= rot_c;
        forward_rotation_r <= rot_c & ~dir_c;
        reverse_rotation_r <= rot_c & dir_c;
      end else begin
        run_r <= 1'b0;
        forward_rotation_r <= 1'b0;
        reverse_rotation_r <= 1'b0;
      end
      front_light_r <= front_light_param;
      bottom_light_r <= bottom_light_param;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // history view, hold-to-clear, beep
  reg [31:0] hold_r;
  reg [31:0] beep_cnt_r;
  reg hold_done_r;
  reg hist_clr_r;
  wire [CODE_W-1:0] hist_code;
  wire [2:0] hist_cnt;
  wire in_hist;
  assign in_hist = (view_sel == `SXC_VIEW_ERRHIST);

  sxc_err_hist #(.CODE_W(CODE_W), .DEPTH(`SXC_ERR_DEPTH)) u_hist (
    .mclk(mclk),
    .rstn(rstn),
    .err_valid(err_valid),
    .err_code(err_code),
    .clear(hist_clr_r),
    .rd_slot(hist_slot),
    .rd_code_r(hist_code),
    .count_r(hist_cnt)
  );

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hold_r <= 32'h0;
      hold_done_r <= 1'b0;
      hist_clr_r <= 1'b0;
      beep_cnt_r <= 32'h0;
      beep_r <= 1'b0;
    end else begin
      hist_clr_r <= 1'b0;
      if (!(in_hist && btn_c)) begin
        hold_r <= 32'h0;
        hold_done_r <= 1'b0;
      end else if (!hold_done_r) begin
        if (hold_r == HOLD_CYC - 32'h1) begin
          hold_done_r <= 1'b1;
          hist_clr_r <= 1'b1;
          beep_cnt_r <= BEEP_CYC;
        end else begin
          hold_r <= hold_r + 32'h1;
        end
      end
      if (beep_cnt_r != 32'h0 && !(hist_clr_r == 1'b0 && hold_r == HOLD_CYC - 32'h1
          && in_hist && btn_c && !hold_done_r)) begin
        beep_cnt_r <= beep_cnt_r - 32'h1;
      end
      beep_r <= (beep_cnt_r != 32'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // indicator
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      indicator_r <= 16'h0;
    end else begin
      if (view_sel == `SXC_VIEW_PARAM) begin
        indicator_r <= {1'b0, speed_source_param, legacy_curve_param, signal_start_param,
                        air_override_param, estop_enable_param, max1_en_param,
                        max2_en_param, fixed1_en_param, fixed2_en_param, 1'b0,
                        front_light_param, bottom_light_param};
      end else if (view_sel == `SXC_VIEW_VERSION) begin
        indicator_r <= VERSION;
      end else if (in_hist) begin
        indicator_r <= {5'h0, hist_cnt, hist_code};
      end else begin
        indicator_r <= speed_cmd_r;
      end
    end
  end
endmodule // sxc_top

// ==== sxc_props.sv ====
// assertion checker for the spindle external command logic
`timescale 1ns/10ps
module sxc_props #(
  parameter [31:0] DEB_CYC = 32'h3d090,
  parameter [31:0] BEEP_CYC = 32'h017d7840,
  parameter [15:0] VERSION = 16'h0100
) (
  input wire mclk,
  input wire rstn,
  input wire [1:0] speed_source_param,
  input wire air_override_param,
  input wire estop_enable_param,
  input wire [1:0] front_light_param,
  input wire [1:0] bottom_light_param,
  input wire estop_in_first,
  input wire estop_in_second,
  input wire air_ok_in,
  input wire [1:0] view_sel,
  input wire [15:0] speed_cmd_r,
  input wire forward_rotation_r,
  input wire reverse_rotation_r,
  input wire estop_trip_r,
  input wire motor_power_en_r,
  input wire nv_write_r,
  input wire [1:0] front_light_r,
  input wire [1:0] bottom_light_r,
  input wire [15:0] indicator_r,
  input wire beep_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  reg [31:0] beep_cnt_r;
  reg [31:0] open_cnt_r;
  ////////////////////////////////
  // beep length and open-contact counters
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      beep_cnt_r <= 32'h0;
      open_cnt_r <= 32'h0;
    end else begin
      beep_cnt_r <= beep_r ? beep_cnt_r + 32'h1 : 32'h0;
      open_cnt_r <= (estop_enable_param && !estop_in_first && !estop_in_second) ?
        open_cnt_r + 32'h1 : 32'h0;
    end
  end
  sequence s_air_bare;
    (air_override_param && !air_ok_in)[*3];
  endsequence
  sequence s_ver_view;
    (view_sel == 2'h2)[*3];
  endsequence
  sequence s_lights_still;
    ($stable(front_light_param) && $stable(bottom_light_param))[*2];
  endsequence
  AST_ESTOP_TRIP: assert property (open_cnt_r == DEB_CYC + 32'h8 |-> estop_trip_r && !motor_power_en_r)
    else $error("no trip after both inputs open");
  AST_TRIP_CAUSE: assert property ($rose(estop_trip_r) |-> $past(estop_enable_param))
    else $error("trip with stop function off");
  AST_SPEED_RANGE: assert property (speed_cmd_r >= 16'h03e8 && speed_cmd_r <= 16'hc350)
    else $error("speed command out of range");
  AST_AIR_CAP: assert property (s_air_bare |-> speed_cmd_r <= 16'h7530)
    else $error("speed above cap without air");
  AST_NV_PULSE: assert property (nv_write_r |=> !nv_write_r)
    else $error("store strobe too long");
  AST_NV_MODE: assert property (nv_write_r |-> $past(speed_source_param) == 2'h1)
    else $error("store strobe outside pulse mode");
  AST_BEEP_LEN: assert property ($fell(beep_r) |-> beep_cnt_r == BEEP_CYC)
    else $error("beep length wrong");
  AST_BEEP_SRC: assert property ($rose(beep_r) |-> $past(view_sel) == 2'h3)
    else $error("beep outside history view");
  AST_DIR_EXCL: assert property (!(forward_rotation_r && reverse_rotation_r))
    else $error("both directions active");
  AST_LIGHTS: assert property (s_lights_still |-> front_light_r == front_light_param &&
    bottom_light_r == bottom_light_param)
    else $error("light level not followed");
  AST_VERSION: assert property (s_ver_view |-> indicator_r == VERSION)
    else $error("version view wrong");
endmodule // sxc_props
bind sxc_top sxc_props #(.DEB_CYC(DEB_CYC), .BEEP_CYC(BEEP_CYC), .VERSION(VERSION)) u_props (.*);

// ==== sxc_host_model.sv ====
// machine control side driving the speed select and estop contact inputs
`timescale 1ns/10ps
module sxc_host_model #(
  parameter ON_CYC = 8,
  parameter GAP_CYC = 8
) (
  input wire mclk,
  input wire rstn,
  input wire pulse_mode,
  input wire pulse_req,
  input wire up,
  input wire [1:0] sel_lvl,
  input wire [1:0] estop_open,
  output reg speed_select_low,
  output reg speed_select_high,
  output reg estop_in_first,
  output reg estop_in_second,
  output wire busy
);
  reg [7:0] cnt_r;
  assign busy = cnt_r != 8'h0;
  ////////////////////////////////
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 8'h0;
      speed_select_low <= 1'b0;
      speed_select_high <= 1'b0;
      estop_in_first <= 1'b1;
      estop_in_second <= 1'b1;
    end else begin
      if (pulse_req && !busy) begin
        cnt_r <= 8'(ON_CYC + GAP_CYC);
      end else if (busy) begin
        cnt_r <= cnt_r - 8'h1;
      end
      speed_select_low <= pulse_mode ? up : sel_lvl[0];
      speed_select_high <= pulse_mode ? (cnt_r > GAP_CYC) : sel_lvl[1];
      estop_in_first <= !estop_open[0];
      estop_in_second <= !estop_open[1];
    end
  end
endmodule // sxc_host_model

// ==== sxc_tb.sv ====
// self-checking testbench for the spindle external command logic
`timescale 1ns/10ps
module testbench;
  logic mclk = 0, rstn = 0, legacy_curve_param = 0, signal_start_param = 0;
  logic air_override_param = 0, estop_enable_param = 0, max1_en_param = 0, max2_en_param = 0;
  logic fixed1_en_param = 0, fixed2_en_param = 0, motor_choice_in = 0, dir_in = 0;
  logic rotate_cmd_in = 0, air_ok_in = 1, point_wr = 0, point_wr_motor = 0, nv_load = 0;
  logic err_valid = 0, start_stop_btn = 0, pulse_req = 0, up = 0;
  logic [1:0] speed_source_param = 0, front_light_param = 0, bottom_light_param = 0;
  logic [1:0] view_sel = 0, point_wr_idx = 0, sel_lvl = 0, estop_open = 0;
  logic [15:0] max1_speed_param = 16'hc350, max2_speed_param = 16'hc350;
  logic [15:0] fixed1_speed_param = 16'h4e20, fixed2_speed_param = 16'h4e20;
  logic [15:0] analog_speed_in_first = 16'h1388, analog_speed_in_second = 16'h1b58;
  logic [15:0] analog_legacy_first = 16'h3a98, analog_legacy_second = 16'h2328;
  logic [15:0] point_wr_speed = 0, nv_speed1 = 0, nv_speed2 = 0;
  logic [7:0] err_code = 0;
  logic [2:0] hist_slot = 0;
  wire speed_select_low, speed_select_high, estop_in_first, estop_in_second, busy;
  wire run_r, forward_rotation_r, reverse_rotation_r, estop_trip_r, motor_power_en_r;
  wire nv_write_r, beep_r;
  wire [15:0] speed_cmd_r, nv_wr_speed1_r, nv_wr_speed2_r, indicator_r;
  wire [1:0] front_light_r, bottom_light_r;
  int n_fail = 0, checked = 0, n_nv = 0;
  sxc_top #(.DEB_CYC(18'h4), .HOLD_CYC(32'h14), .BEEP_CYC(32'h5)) DUT (.*);
  sxc_host_model u_host (.*, .pulse_mode(speed_source_param == 2'h1));
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (nv_write_r === 1'b1) n_nv <= n_nv + 1;
  ////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic look;
    tick(16);
    @(negedge mclk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic pulse(input logic dir);
    tick(1);
    up <= dir;
    tick(12);
    pulse_req <= 1'b1;
    tick(1);
    pulse_req <= 1'b0;
    look;
    look;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////
  task automatic t_analog;
    look;
    chk(speed_cmd_r, 16'h1388);
    tick(1);
    motor_choice_in <= 1'b1;
    look;
    chk(speed_cmd_r, 16'h1b58);
    tick(1);
    legacy_curve_param <= 1'b1;
    look;
    chk(speed_cmd_r, 16'h2328);
    tick(1);
    legacy_curve_param <= 1'b0;
    fixed2_en_param <= 1'b1;
    fixed2_speed_param <= 16'h61a8;
    look;
    chk(speed_cmd_r, 16'h61a8);
    tick(1);
    motor_choice_in <= 1'b0;
    fixed1_en_param <= 1'b1;
    look;
    chk(speed_cmd_r, 16'h4e20);
    tick(1);
    fixed1_en_param <= 1'b0;
    fixed2_en_param <= 1'b0;
    $display("done analog");
  endtask
  task automatic t_pulse;
    speed_source_param <= 2'h1;
    look;
    chk(speed_cmd_r, 16'h2710);
    pulse(1'b1);
    chk(speed_cmd_r, 16'h2af8);
    chk(nv_wr_speed1_r, 16'h2af8);
    chk(16'(n_nv), 16'h1);
    tick(1);
    max1_en_param <= 1'b1;
    max1_speed_param <= 16'h2ee0;
    pulse(1'b1);
    pulse(1'b1);
    chk(speed_cmd_r, 16'h2ee0);
    tick(1);
    max1_en_param <= 1'b0;
    pulse(1'b0);
    chk(speed_cmd_r, 16'h2af8);
    repeat (11) pulse(1'b0);
    chk(speed_cmd_r, 16'h03e8);
    tick(1);
    motor_choice_in <= 1'b1;
    pulse(1'b1);
    chk(nv_wr_speed2_r, 16'h2af8);
    chk(nv_wr_speed1_r, 16'h03e8);
    tick(1);
    nv_load <= 1'b1;
    nv_speed1 <= 16'h4e20;
    nv_speed2 <= 16'h7530;
    tick(1);
    nv_load <= 1'b0;
    look;
    chk(speed_cmd_r, 16'h7530);
    tick(1);
    motor_choice_in <= 1'b0;
    look;
    chk(speed_cmd_r, 16'h4e20);
    tick(1);
    $display("done pulse");
  endtask
  task automatic t_point;
    speed_source_param <= 2'h2;
    for (int k = 0; k < 8; k++) begin
      point_wr <= 1'b1;
      point_wr_motor <= k[2];
      point_wr_idx <= k[1:0];
      point_wr_speed <= 16'(k * 8000 + 1000);
      tick(1);
    end
    point_wr <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      motor_choice_in <= k[2];
      sel_lvl <= k[1:0];
      look;
      chk(speed_cmd_r, k == 7 ? 16'hc350 : 16'(k * 8000 + 1000));
      tick(1);
    end
    motor_choice_in <= 1'b0;
    speed_source_param <= 2'h0;
    $display("done point");
  endtask
  task automatic t_start;
    signal_start_param <= 1'b1;
    rotate_cmd_in <= 1'b1;
    look;
    chkb(run_r, 1'b1);
    chkb(forward_rotation_r, 1'b1);
    tick(1);
    rotate_cmd_in <= 1'b0;
    dir_in <= 1'b1;
    look;
    tick(1);
    rotate_cmd_in <= 1'b1;
    look;
    chkb(reverse_rotation_r, 1'b1);
    tick(1);
    rotate_cmd_in <= 1'b0;
    signal_start_param <= 1'b0;
    look;
    tick(1);
    rotate_cmd_in <= 1'b1;
    look;
    chkb(run_r, 1'b0);
    tick(1);
    signal_start_param <= 1'b1;
    air_ok_in <= 1'b0;
    analog_speed_in_first <= 16'h9c40;
    look;
    chkb(run_r, 1'b0);
    tick(1);
    air_override_param <= 1'b1;
    look;
    chkb(run_r, 1'b1);
    chk(speed_cmd_r, 16'h7530);
    chk(indicator_r, 16'h7530);
    $display("done start");
  endtask
  task automatic t_estop;
    tick(1);
    estop_open <= 2'h3;
    look;
    chkb(estop_trip_r, 1'b0);
    tick(1);
    estop_open <= 2'h1;
    estop_enable_param <= 1'b1;
    look;
    chkb(estop_trip_r, 1'b0);
    chkb(motor_power_en_r, 1'b1);
    tick(1);
    estop_open <= 2'h3;
    look;
    chkb(estop_trip_r, 1'b1);
    chkb(motor_power_en_r, 1'b0);
    $display("done estop");
  endtask
  task automatic t_lights;
    for (int k = 0; k < 4; k++) begin
      tick(1);
      front_light_param <= 2'(k);
      bottom_light_param <= 2'(3 - k);
      look;
      chk({14'h0, front_light_r}, 16'(k));
      chk({14'h0, bottom_light_r}, 16'(3 - k));
    end
    $display("done lights");
  endtask
  task automatic t_hist;
    tick(1);
    view_sel <= 2'h3;
    for (int k = 1; k < 7; k++) begin
      err_valid <= 1'b1;
      err_code <= 8'(8'h10 + k);
      tick(1);
    end
    err_valid <= 1'b0;
    for (int s = 1; s < 6; s++) begin
      hist_slot <= 3'(s);
      look;
      chk(indicator_r, {5'h0, 3'h5, 8'(8'h17 - s)});
      tick(1);
    end
    view_sel <= 2'h2;
    look;
    chk(indicator_r, 16'h0100);
    tick(1);
    view_sel <= 2'h1;
    look;
    chk(indicator_r, 16'h0e0c);
    tick(1);
    view_sel <= 2'h3;
    start_stop_btn <= 1'b1;
    for (int i = 0; i < 80 && beep_r !== 1'b1; i++) @(negedge mclk);
    chkb(beep_r, 1'b1);
    tick(1);
    start_stop_btn <= 1'b0;
    hist_slot <= 3'h1;
    look;
    chk(indicator_r, 16'h0);
    $display("done history");
  endtask
  ////////////////////////////////
  initial begin
    tick(20000);
    n_fail++;
    final_report;
  end
  initial begin
    tick(6);
    @(negedge mclk);
    chk(speed_cmd_r, 16'h03e8);
    chk(nv_wr_speed1_r, 16'h2710);
    tick(6);
    rstn <= 1'b1;
    t_analog;
    t_pulse;
    t_point;
    t_start;
    t_estop;
    t_lights;
    t_hist;
    final_report;
  end
endmodule // testbench
